// >>> verilog/dedc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dedc_defs.vh"

// Behaviour
// [R1] During deployment, monitor messages execute for all channels with status reply.
// [R2] During deployment, diagnostic messages are discarded and answered with fault reply.
// [R3] Enable is active high; drivers turn on only while enabled.
// [R4] Dropping enable never aborts a deployment already running.
// [R5] Drivers held off while enable is low; message handling continues; the code keeps the drivers of a running deployment on.
// [R6] MOS diagnostic runs with enable low, driver stays off, threshold bits set.
// [R7] With enable low, a deploy command cannot start the stretch timer.
// [R8] Deploy command status reports previous transfer's command bits always; the code updates it only on command-mode transfers.
// [R9] Arming signal starts the stretch timer regardless of enable.
// [R10] A running stretch timer ignores enable changes.
// [R11] Enable changes shorter than the deglitch time are ignored.
// [R12] Reply to a message is sent in the following transfer.
// [R13] Each source and sink switched by command; high pulldown follows bias.
// [R14] Current channel selected independently of monitored channel.
// [R15] Continuity diagnostic turns on bias source on selected channel.
// [R16] High pin above battery threshold flags short to battery.
// [R17] Low pin below ground threshold flags short to ground or open.
// [R18] Resistance measurement turns on measurement source and sink.
// [R19] Host checks shorts before requesting a MOS diagnostic.
// [R20] Enable dropped during MOS diagnostic keeps driver off and reports failure.
// [R21] During deployment, register messages are discarded with fault reply.
// [R22] Deglitch counter accepts a new level after a full stable period.
module dedc_ctrl #(
	parameter [`DEDC_PST_W-1:0] STRETCH_CYCLES = `DEDC_PST_DEF
) (
	input wire ref_clk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire deploy_enable_pin_i,
	input wire arm_pin_i,
	input wire msg_valid_i,
	input wire [`DEDC_MSG_W-1:0] msg_i,
	input wire [`DEDC_NCH-1:0] deploy_cmd_i,
	input wire [`DEDC_NCH-1:0] deploy_done_i,
	input wire [`DEDC_OP_W-1:0] diag_op_i,
	input wire [`DEDC_CHW-1:0] cur_ch_i,
	input wire [`DEDC_CHW-1:0] mon_ch_i,
	input wire src_on_i,
	input wire sink_on_i,
	input wire bias_on_i,
	input wire [`DEDC_NCH-1:0] sqh_above_battery_short_threshold_i,
	input wire [`DEDC_NCH-1:0] sql_below_ground_short_threshold_i,
	input wire [`DEDC_NCH-1:0] vdiff_above_i,
	output reg [`DEDC_NCH-1:0] hs_drv_o,
	output reg [`DEDC_NCH-1:0] ls_drv_o,
	output reg [`DEDC_NCH-1:0] measure_current_source_o,
	output reg [`DEDC_NCH-1:0] measure_current_sink_o,
	output reg [`DEDC_NCH-1:0] bias_current_source_o,
	output reg [`DEDC_NCH-1:0] high_pin_pulldown_o,
	output reg [`DEDC_CHW-1:0] mon_sel_o,
	output reg stretch_run_o,
	output reg deploying_o,
	output reg [`DEDC_NCH-1:0] deploy_cmd_status_o,
	output reg [2:0] reply_kind_o,
	output reg reply_valid_o,
	output reg exec_o,
	output reg [`DEDC_MSG_W-1:0] exec_msg_o,
	output reg battery_short_o,
	output reg ground_short_o,
	output reg vdiff_flag_o,
	output reg mos_fail_o,
	output reg mos_busy_o,
	output reg enable_level_o
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CHECK = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	localparam [1:0] ST_DONE = 2'h3;

	wire en_dgl;
	reg arm1;
	reg arm2;
	reg arm3;
	reg arm_seen;
	reg [`DEDC_PST_W-1:0] pst_cnt;
	reg [`DEDC_NCH-1:0] deploy_act;
	reg [1:0] mos_st;
	reg [`DEDC_OP_W-1:0] mos_op;
	reg [`DEDC_TMO_W-1:0] mos_cnt;
	reg mos_en_lost;
	reg [`DEDC_NCH-1:0] next_hs;
	reg [`DEDC_NCH-1:0] next_ls;
	reg [`DEDC_OP_W-1:0] cur_op;

	// One-hot decode of a channel number, used for both the current and driver paths.
	function [`DEDC_NCH-1:0] ch_onehot;
		input [`DEDC_CHW-1:0] ch;
		begin
			ch_onehot = {{(`DEDC_NCH-1){1'b0}}, 1'b1} << ch;
		end
	endfunction

	function is_mos;
		input [`DEDC_OP_W-1:0] op;
		begin
			is_mos = (op == `DEDC_OP_LSMOS) || (op == `DEDC_OP_HSMOS);
		end
	endfunction

	dedc_deglitch i_dedc_deglitch (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.pin_i(deploy_enable_pin_i),
		.level_o(en_dgl)
	);

	wire [1:0] mode = msg_i[`DEDC_MODE_HI:`DEDC_MODE_LO];
	wire deploy_any = |deploy_act;
	wire arm_ok = arm2 & arm3;
	wire arm_rise = arm_ok & ~arm_seen;
	wire cmd_any = msg_valid_i && (mode == `DEDC_MODE_CMD) && (|deploy_cmd_i);
	wire pst_start = arm_rise | (cmd_any & en_dgl); // [R7] [R9]
	wire pst_run = (pst_cnt != {`DEDC_PST_W{1'b0}});

	// Arming line is a pin: three stages, accepted when stages two and three agree.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			arm1 <= 1'b0;
			arm2 <= 1'b0;
			arm3 <= 1'b0;
			arm_seen <= 1'b0;
		end else if (ce_i) begin
			arm1 <= arm_pin_i;
			arm2 <= arm1;
			arm3 <= arm2;
			if (arm2 == arm3) begin
				arm_seen <= arm3;
			end
		end
	end

	// Once started the timer counts out on its own; enable is not looked at here.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pst_cnt <= {`DEDC_PST_W{1'b0}};
		end else if (ce_i) begin
			if (pst_start && !pst_run) begin
				pst_cnt <= STRETCH_CYCLES; // [R9]
			end else if (pst_run) begin
				pst_cnt <= pst_cnt - 1'b1; // [R10]
			end
		end
	end

	// A deployment latches while enabled and runs until the firing logic reports its end.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			deploy_act <= {`DEDC_NCH{1'b0}};
		end else if (ce_i) begin
			deploy_act <= (deploy_act & ~deploy_done_i) // [R4]
				| ((cmd_any && en_dgl && (pst_run || pst_start)) ? deploy_cmd_i : {`DEDC_NCH{1'b0}}); // [R3]
		end
	end

	// Message handling: the reply kind is registered and sent in the next transfer.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reply_kind_o <= `DEDC_RPL_REG;
			reply_valid_o <= 1'b0;
			exec_o <= 1'b0;
			exec_msg_o <= {`DEDC_MSG_W{1'b0}};
			deploy_cmd_status_o <= {`DEDC_NCH{1'b0}};
		end else if (ce_i) begin
			exec_o <= 1'b0;
			reply_valid_o <= msg_valid_i; // [R12]
			if (msg_valid_i) begin
				exec_msg_o <= msg_i;
				if (mode == `DEDC_MODE_CMD) begin
					deploy_cmd_status_o <= deploy_cmd_i; // [R8]
				end
				case (mode)
					`DEDC_MODE_REG: begin
						reply_kind_o <= deploy_any ? `DEDC_RPL_FAULT : `DEDC_RPL_REG; // [R21]
						exec_o <= ~deploy_any;
					end
					`DEDC_MODE_CMD: begin
						reply_kind_o <= `DEDC_RPL_CMD;
						exec_o <= 1'b1;
					end
					`DEDC_MODE_DIAG: begin
						reply_kind_o <= deploy_any ? `DEDC_RPL_FAULT : `DEDC_RPL_DIAG; // [R2]
						exec_o <= ~deploy_any;
					end
					default: begin
						reply_kind_o <= `DEDC_RPL_STAT; // [R1]
						exec_o <= 1'b1;
					end
				endcase
			end
		end
	end

	// Diagnostic messages are only taken outside deployment.
	always @* begin
		cur_op = `DEDC_OP_NONE;
		if (msg_valid_i && mode == `DEDC_MODE_DIAG && !deploy_any) begin
			cur_op = diag_op_i; // [R2]
		end
	end

	// MOS diagnostic sequencer; a missing enable fails the test rather than firing.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mos_st <= ST_IDLE;
			mos_op <= `DEDC_OP_NONE;
			mos_cnt <= {`DEDC_TMO_W{1'b0}};
			mos_en_lost <= 1'b0;
			mos_fail_o <= 1'b0;
			mos_busy_o <= 1'b0;
		end else if (ce_i) begin
			case (mos_st)
				ST_IDLE: begin
					mos_busy_o <= 1'b0;
					if (is_mos(cur_op)) begin
						mos_op <= cur_op;
						mos_en_lost <= ~en_dgl; // [R6]
						mos_fail_o <= 1'b0;
						mos_busy_o <= 1'b1;
						mos_st <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					mos_cnt <= `DEDC_MOS_TMO;
					if (sqh_above_battery_short_threshold_i[cur_ch_i] || sql_below_ground_short_threshold_i[cur_ch_i]) begin
						mos_fail_o <= 1'b1;
						mos_st <= ST_DONE;
					end else begin
						mos_st <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!en_dgl) begin
						mos_en_lost <= 1'b1; // [R20]
					end
					if (sqh_above_battery_short_threshold_i[cur_ch_i] || sql_below_ground_short_threshold_i[cur_ch_i] || vdiff_above_i[cur_ch_i]) begin
						mos_fail_o <= mos_en_lost | ~en_dgl; // [R20]
						mos_st <= ST_DONE;
					end else if (mos_cnt == {`DEDC_TMO_W{1'b0}}) begin
						mos_fail_o <= 1'b1;
						mos_st <= ST_DONE;
					end else begin
						mos_cnt <= mos_cnt - 1'b1;
					end
				end
				default: begin
					mos_busy_o <= 1'b0;
					mos_st <= ST_IDLE;
				end
			endcase
		end
	end

	// Driver gating: enable low holds every driver off, but an active deployment keeps firing.
	always @* begin
		next_hs = deploy_act; // [R4]
		next_ls = deploy_act;
		if (mos_st == ST_RUN && en_dgl && !mos_en_lost) begin
			if (mos_op == `DEDC_OP_HSMOS) begin
				next_hs = next_hs | ch_onehot(cur_ch_i); // [R3]
			end else begin
				next_ls = next_ls | ch_onehot(cur_ch_i);
			end
		end
	end

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hs_drv_o <= {`DEDC_NCH{1'b0}};
			ls_drv_o <= {`DEDC_NCH{1'b0}};
			measure_current_source_o <= {`DEDC_NCH{1'b0}};
			measure_current_sink_o <= {`DEDC_NCH{1'b0}};
			bias_current_source_o <= {`DEDC_NCH{1'b0}};
			high_pin_pulldown_o <= {`DEDC_NCH{1'b0}};
			mon_sel_o <= {`DEDC_CHW{1'b0}};
			battery_short_o <= 1'b0;
			ground_short_o <= 1'b0;
			vdiff_flag_o <= 1'b0;
			stretch_run_o <= 1'b0;
			deploying_o <= 1'b0;
			enable_level_o <= 1'b0;
		end else if (ce_i) begin
			hs_drv_o <= next_hs; // [R5]
			ls_drv_o <= next_ls; // [R5]
			stretch_run_o <= pst_run;
			deploying_o <= deploy_any;
			enable_level_o <= en_dgl;
			mon_sel_o <= mon_ch_i; // [R14]
			if (cur_op != `DEDC_OP_NONE) begin
				measure_current_source_o <= (src_on_i || cur_op == `DEDC_OP_RES) ?
					ch_onehot(cur_ch_i) : {`DEDC_NCH{1'b0}}; // [R13] [R18]
				measure_current_sink_o <= (sink_on_i || cur_op == `DEDC_OP_RES) ?
					ch_onehot(cur_ch_i) : {`DEDC_NCH{1'b0}}; // [R18]
				bias_current_source_o <= (bias_on_i || cur_op == `DEDC_OP_CONT || is_mos(cur_op)) ?
					ch_onehot(cur_ch_i) : {`DEDC_NCH{1'b0}}; // [R15] [R14]
				high_pin_pulldown_o <= (bias_on_i || cur_op == `DEDC_OP_CONT || is_mos(cur_op)) ?
					ch_onehot(cur_ch_i) : {`DEDC_NCH{1'b0}}; // [R13]
			end
			// Comparators are sampled on the monitored channel, not the driven one.
			battery_short_o <= sqh_above_battery_short_threshold_i[mon_ch_i]; // [R16]
			ground_short_o <= sql_below_ground_short_threshold_i[mon_ch_i]; // [R17]
			vdiff_flag_o <= vdiff_above_i[mon_ch_i]; // [R6]
		end
	end

endmodule // dedc_ctrl
`default_nettype wire

// >>> inc/dedc_defs.vh
`ifndef DEDC_DEFS_VH
`define DEDC_DEFS_VH

// Channel count and width of a channel select.
`define DEDC_NCH 8
`define DEDC_CHW 3

// Message mode, bits 15:14 of a 16-bit message.
`define DEDC_MODE_HI 15
`define DEDC_MODE_LO 14
`define DEDC_MODE_REG 2'h0
`define DEDC_MODE_CMD 2'h1
`define DEDC_MODE_DIAG 2'h2
`define DEDC_MODE_MON 2'h3
`define DEDC_MSG_W 16

// Reply kinds handed to the framing logic.
`define DEDC_RPL_REG 3'h0
`define DEDC_RPL_CMD 3'h2
`define DEDC_RPL_DIAG 3'h4
`define DEDC_RPL_STAT 3'h6
`define DEDC_RPL_FAULT 3'h7

// Diagnostic operation codes.
`define DEDC_OP_NONE 3'h0
`define DEDC_OP_CONT 3'h1
`define DEDC_OP_RES 3'h2
`define DEDC_OP_LSMOS 3'h3
`define DEDC_OP_HSMOS 3'h4
`define DEDC_OP_W 3

// Deglitch time in ns and the clock period in ns.
`define DEDC_DEGLITCH_NS 12000
`define DEDC_CLK_NS 4
`define DEDC_DGL_W 13
// Deglitch time in clock cycles, 12 us at the 4 ns clock, sized to the counter.
`define DEDC_DGL_CYC 13'h0BB8

// MOS diagnostic timeout in cycles.
`define DEDC_MOS_TMO 16'h0FA0
`define DEDC_TMO_W 16

// Pulse stretch timer width.
`define DEDC_PST_W 20
`define DEDC_PST_DEF 20'h7A120

`endif

// >>> verilog/dedc_deglitch.v
`timescale 1ns/1ps
`default_nettype none
`include "dedc_defs.vh"

module dedc_deglitch #(
	parameter [`DEDC_DGL_W-1:0] CYCLES = `DEDC_DGL_CYC
) (
	input wire ref_clk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire pin_i,
	output reg level_o
);

	reg sync1;
	reg sync2;
	reg sync3;
	reg [`DEDC_DGL_W-1:0] cnt;

	// The first stage is read only by the second; the change is judged on stages two and three.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			cnt <= {`DEDC_DGL_W{1'b0}};
			level_o <= 1'b0;
		end else if (ce_i) begin
			sync1 <= pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 != sync3 || sync3 == level_o) begin
				cnt <= {`DEDC_DGL_W{1'b0}}; // [R22]
			end else if (cnt >= CYCLES - 1'b1) begin
				level_o <= sync3; // [R11]
				cnt <= {`DEDC_DGL_W{1'b0}};
			end else begin
				cnt <= cnt + 1'b1; // [R22]
			end
		end
	end

endmodule // dedc_deglitch
`default_nettype wire

// >>> testbench/dedc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dedc_defs.vh"
module dedc_ctrl_assertions (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic deploy_enable_pin_i,
	input wire logic arm_pin_i,
	input wire logic msg_valid_i,
	input wire logic [15:0] msg_i,
	input wire logic [7:0] deploy_cmd_i,
	input wire logic [2:0] diag_op_i,
	input wire logic [2:0] cur_ch_i,
	input wire logic bias_on_i,
	input wire logic [7:0] hs_drv_o,
	input wire logic [7:0] ls_drv_o,
	input wire logic [7:0] measure_current_source_o,
	input wire logic [7:0] measure_current_sink_o,
	input wire logic [7:0] bias_current_source_o,
	input wire logic [7:0] high_pin_pulldown_o,
	input wire logic stretch_run_o,
	input wire logic deploying_o,
	input wire logic [7:0] deploy_cmd_status_o,
	input wire logic [2:0] reply_kind_o,
	input wire logic reply_valid_o,
	input wire logic exec_o,
	input wire logic enable_level_o
);
	logic [11:0] hc;
	wire logic take = msg_valid_i && ce_i;
	wire logic [1:0] md = msg_i[15:14];
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Counts how long the raw pin has been high; it saturates so a long level never wraps.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i || !deploy_enable_pin_i)
			hc <= 12'h000;
		else if (hc != 12'hFFF)
			hc <= hc + 12'h001;
	end
	a_reply_next: assert property (take |=> reply_valid_o) else $error("no reply pulse");
	// One cycle after a message, deploying_o shows the deployment state that the message was judged against.
	a_fault_busy: assert property (take && !md[0]
		|=> ((reply_kind_o == 3'h7) == deploying_o) && (exec_o != deploying_o))
		else $error("message not refused in deployment");
	a_mon_run: assert property (take && md == 2'h3 |=> exec_o && reply_kind_o == 3'h6)
		else $error("monitor message not executed");
	a_cmd_status: assert property (take && md == 2'h1 |=> deploy_cmd_status_o == $past(deploy_cmd_i))
		else $error("command status wrong");
	a_cmd_no_start: assert property (take && md == 2'h1 && !$past(arm_pin_i, 2)
		|=> (!enable_level_o && !stretch_run_o |=> !stretch_run_o)) else $error("timer started while disabled");
	a_arm_start: assert property ($rose(arm_pin_i) |-> ##[1:8] stretch_run_o) else $error("arm ignored");
	a_drv_gate: assert property ($rose(|{hs_drv_o, ls_drv_o}) |-> enable_level_o || $past(enable_level_o))
		else $error("driver on while disabled");
	a_dgl_time: assert property ($rose(enable_level_o) |-> hc >= 12'hBAE) else $error("enable taken early");
	a_res_currents: assert property (take && md == 2'h2 && diag_op_i == 3'h2
		|=> deploying_o || (measure_current_source_o[$past(cur_ch_i)] && measure_current_sink_o[$past(cur_ch_i)]))
		else $error("measure currents off");
	a_pd_bias: assert property ((bias_current_source_o & ~high_pin_pulldown_o) == 8'h00)
		else $error("pulldown not with bias");
	a_bias_cmd: assert property (take && md == 2'h2 && diag_op_i != 3'h0
		&& (bias_on_i || diag_op_i == 3'h1)
		|=> deploying_o || (bias_current_source_o[$past(cur_ch_i)] && high_pin_pulldown_o[$past(cur_ch_i)]))
		else $error("bias or pulldown off");
endmodule // dedc_ctrl_assertions
bind dedc_ctrl dedc_ctrl_assertions i_dedc_ctrl_assertions (.*);
`default_nettype wire

// >>> testbench/dedc_squib_model.sv
`timescale 1ns/1ps
`default_nettype none
module dedc_squib_model #(
	parameter int FIRE = 3500
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] hs_drv_i,
	input wire logic [7:0] ls_drv_i,
	input wire logic [7:0] bat_flt_i,
	input wire logic [7:0] gnd_flt_i,
	output logic [7:0] sqh_above_battery_short_threshold_o,
	output logic [7:0] sql_below_ground_short_threshold_o,
	output logic [7:0] vdiff_above_o,
	output logic [7:0] deploy_done_o
);
	int cnt;
	assign sqh_above_battery_short_threshold_o = bat_flt_i;
	assign sql_below_ground_short_threshold_o = gnd_flt_i;
	// Current flows only where both drivers of a loop conduct.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 0;
			vdiff_above_o <= 8'h00;
		end else begin
			vdiff_above_o <= hs_drv_i & ls_drv_i;
			cnt <= (|hs_drv_i) ? cnt + 1 : 0;
		end
	end
	assign deploy_done_o = (cnt >= FIRE) ? hs_drv_i : 8'h00;
endmodule // dedc_squib_model
`default_nettype wire

// >>> testbench/dedc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dedc_defs.vh"
module dedc_ctrl_bench;
	logic ref_clk_i = 0, rst_b_i = 0, ce_i = 1, deploy_enable_pin_i = 0, arm_pin_i = 0, msg_valid_i = 0;
	logic [15:0] msg_i = 16'h0000;
	logic [7:0] deploy_cmd_i = 8'h00, bat_flt = 8'h00, gnd_flt = 8'h00;
	logic [2:0] diag_op_i = 3'h0, cur_ch_i = 3'h0, mon_ch_i = 3'h0, mon_sel_o, reply_kind_o;
	logic src_on_i = 0, sink_on_i = 0, bias_on_i = 0;
	logic [7:0] deploy_done_i, sqh_above_battery_short_threshold_i, sql_below_ground_short_threshold_i, vdiff_above_i, hs_drv_o, ls_drv_o;
	logic [7:0] measure_current_source_o, measure_current_sink_o, bias_current_source_o, high_pin_pulldown_o;
	logic [7:0] deploy_cmd_status_o;
	logic [15:0] exec_msg_o;
	logic stretch_run_o, deploying_o, reply_valid_o, exec_o, battery_short_o, ground_short_o;
	logic vdiff_flag_o, mos_fail_o, mos_busy_o, enable_level_o;
	int num_errors = 0, n_checks = 0, cyc = 0;
	initial forever #2 ref_clk_i = ~ref_clk_i;
	// Long enough to outlast a deglitch wait, short enough to expire before the arming test.
	dedc_ctrl #(.STRETCH_CYCLES(20'h00C80)) i_dedc_ctrl (.*);
	dedc_squib_model #(.FIRE(3500)) i_dedc_squib_model (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.hs_drv_i(hs_drv_o), .ls_drv_i(ls_drv_o), .bat_flt_i(bat_flt), .gnd_flt_i(gnd_flt),
		.sqh_above_battery_short_threshold_o(sqh_above_battery_short_threshold_i), .sql_below_ground_short_threshold_o(sql_below_ground_short_threshold_i),
		.vdiff_above_o(vdiff_above_i), .deploy_done_o(deploy_done_i));
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task send(input logic [1:0] m, input logic [2:0] o, input logic [7:0] c);
		@(posedge ref_clk_i);
		msg_valid_i <= 1;
		msg_i <= {m, 14'h0000};
		diag_op_i <= o;
		deploy_cmd_i <= c;
		@(posedge ref_clk_i);
		msg_valid_i <= 0;
		#1;
		chk("reply_valid", reply_valid_o, 1);
	endtask
	// The slowest path is a MOS timeout plus five deglitch waits; the ceiling leaves twice that.
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			give_verdict;
		end
	end
	initial begin
		wt(6);
		rst_b_i <= 1;
		wt(2);
		send(`DEDC_MODE_CMD, 0, 8'h05);
		wt(4);
		chk("stretch_run", stretch_run_o, 0);
		chk("hs_drv", hs_drv_o, 0);
		send(`DEDC_MODE_MON, 0, 8'h00);
		chk("reply_kind", reply_kind_o, `DEDC_RPL_STAT);
		chk("cmd_status", deploy_cmd_status_o, 8'h05);
		wt(1);
		ce_i <= 0;
		msg_valid_i <= 1;
		msg_i <= {`DEDC_MODE_REG, 14'h0000};
		wt(2);
		msg_valid_i <= 0;
		ce_i <= 1;
		wt(2);
		chk("reply_valid", reply_valid_o, 0);
		chk("reply_kind", reply_kind_o, `DEDC_RPL_STAT);
		$display("test disabled_command done");
		cur_ch_i <= 2;
		mon_ch_i <= 5;
		bias_on_i <= 1;
		src_on_i <= 1;
		bat_flt <= 8'h20;
		send(`DEDC_MODE_DIAG, `DEDC_OP_CONT, 8'h00);
		wt(4);
		chk("bias", bias_current_source_o, 8'h04);
		chk("pulldown", high_pin_pulldown_o, 8'h04);
		chk("source", measure_current_source_o, 8'h04);
		chk("sink", measure_current_sink_o, 8'h00);
		chk("mon_sel", mon_sel_o, 5);
		chk("battery_short", battery_short_o, 1);
		bias_on_i <= 0;
		src_on_i <= 0;
		bat_flt <= 8'h00;
		gnd_flt <= 8'h20;
		send(`DEDC_MODE_DIAG, `DEDC_OP_RES, 8'h00);
		wt(4);
		chk("source", measure_current_source_o, 8'h04);
		chk("sink", measure_current_sink_o, 8'h04);
		chk("pulldown", high_pin_pulldown_o, 8'h00);
		chk("ground_short", ground_short_o, 1);
		chk("battery_short", battery_short_o, 0);
		$display("test diagnostics done");
		src_on_i <= 0;
		sink_on_i <= 0;
		gnd_flt <= 8'h00;
		mon_ch_i <= 2;
		send(`DEDC_MODE_DIAG, `DEDC_OP_LSMOS, 8'h00);
		wt(3);
		for (int i = 0; i < 4200 && mos_busy_o !== 1'b0; i++)
			@(posedge ref_clk_i);
		#1;
		chk("mos_fail", mos_fail_o, 1);
		chk("ls_drv", ls_drv_o, 0);
		$display("test mos_disabled done");
		deploy_enable_pin_i <= 1;
		wt(100);
		deploy_enable_pin_i <= 0;
		wt(3100);
		chk("enable_level", enable_level_o, 0);
		deploy_enable_pin_i <= 1;
		wt(3100);
		chk("enable_level", enable_level_o, 1);
		deploy_enable_pin_i <= 0;
		wt(100);
		deploy_enable_pin_i <= 1;
		wt(3100);
		chk("enable_level", enable_level_o, 1);
		$display("test deglitch done");
		send(`DEDC_MODE_DIAG, `DEDC_OP_HSMOS, 8'h00);
		wt(3);
		chk("hs_drv", hs_drv_o, 8'h04);
		gnd_flt <= 8'h04;
		wt(3);
		chk("mos_fail", mos_fail_o, 0);
		chk("hs_drv", hs_drv_o, 8'h00);
		chk("ground_short", ground_short_o, 1);
		gnd_flt <= 8'h00;
		$display("test mos_enabled done");
		send(`DEDC_MODE_CMD, 0, 8'h01);
		wt(4);
		chk("hs_drv", hs_drv_o, 8'h01);
		chk("ls_drv", ls_drv_o, 8'h01);
		send(`DEDC_MODE_DIAG, `DEDC_OP_CONT, 8'h00);
		chk("reply_kind", reply_kind_o, `DEDC_RPL_FAULT);
		send(`DEDC_MODE_REG, 0, 8'h00);
		chk("reply_kind", reply_kind_o, `DEDC_RPL_FAULT);
		send(`DEDC_MODE_MON, 0, 8'h00);
		chk("exec", exec_o, 1);
		deploy_enable_pin_i <= 0;
		wt(3100);
		chk("enable_level", enable_level_o, 0);
		chk("hs_drv", hs_drv_o, 8'h01);
		chk("deploying", deploying_o, 1);
		wt(500);
		chk("deploying", deploying_o, 0);
		chk("hs_drv", hs_drv_o, 8'h00);
		$display("test deployment done");
		arm_pin_i <= 1;
		wt(8);
		chk("stretch_run", stretch_run_o, 1);
		arm_pin_i <= 0;
		deploy_enable_pin_i <= 1;
		wt(3100);
		chk("enable_level", enable_level_o, 1);
		chk("stretch_run", stretch_run_o, 1);
		wt(200);
		chk("stretch_run", stretch_run_o, 0);
		$display("test arming done");
		give_verdict;
	end
endmodule // dedc_ctrl_bench
`default_nettype wire
